// ### pxafe_ctrl.sv
// Purpose: register control and comparator debounce of a proximity AFE
// Assumes: AXI4-Lite slave on clk_in; analog results synchronous to clk_in
// Notes:   analog blocks sit outside; this drives their enables and codes
//
// Overview of operation
// - amp one enable clear: amp one off, its output high impedance.
// - amp zero enable clear: amp zero off, its output high impedance.
// - comparator/DAC enable clear: comparator forced low, DAC high Z.
// - edge field: 00 none, 01 rising, 10 falling, 11 both edges.
// - debounce code 000 passes the raw comparator result straight through.
// - codes 001..111 filter over about 2^n system clock periods.
// - each amp has a bandwidth bit: 0 low current, 1 high bandwidth.
// - two-bit hysteresis and two-bit bias fields, read/write, reset zero.
// - each amp's calibration output is a read-only status bit.
// - reference DAC driven by an 8-bit read/write code.
// - mode bit picks calibration; ref bit picks non-inverting input.
// - each amp has a 6-bit trim field resetting to 100000.
// - read-only comparator result: 1 when input exceeds DAC level.
// - comparator has mode, ref select, 5-bit trim resetting to 10000.
// - interrupt raised on the selected edge of the filtered result.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "pxafe_map.svh"

module pxafe_ctrl (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        comparator_raw_in,
  input  wire logic        amp_zero_cal_output_in,
  input  wire logic        amp_one_cal_output_in,
  output logic             amp_zero_on_out,
  output logic             amp_one_on_out,
  output logic             comparator_dac_on_out,
  output logic             amp_zero_speed_select_out,
  output logic             amp_one_speed_select_out,
  output logic [1:0]       hysteresis_select_out,
  output logic [1:0]       comparator_bias_select_out,
  output logic [7:0]       reference_dac_code_out,
  output logic [7:0]       amp_zero_trim_out,
  output logic [7:0]       amp_one_trim_out,
  output logic [6:0]       comparator_trim_out,
  output logic             filtered_comparator_result_out,
  output logic             proximity_irq_out
);

  // ============================================================
  // register state
  logic [7:0] ctrl0_q, ctrl0_d;
  logic [5:0] ctrl1_q, ctrl1_d;
  logic [7:0] dac_q, dac_d;
  logic [7:0] trim0_q, trim0_d;
  logic [7:0] trim1_q, trim1_d;
  logic [6:0] ctrim_q, ctrim_d;
  logic       aw_got_q, aw_got_d;
  logic       w_got_q, w_got_d;
  logic [7:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic       wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  pxafe_pkg::pxafe_state_t st_q, st_d;
  // debounce and interrupt state
  logic       cmp_q, cmp_d;
  logic       raw_last_q, raw_last_d;
  logic [6:0] deb_cnt_q, deb_cnt_d;
  logic       filt_q, filt_d;
  logic       irq_q, irq_d;
  logic [6:0] deb_limit;
  logic       wr_fire;
  logic [7:0] awa, wda;

  // ============================================================
  // write capture: address and data in either order
  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    waddr_d  = waddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    if (s_axi_awvalid_in && !aw_got_q) begin
      aw_got_d = 1'b1;
      waddr_d  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !w_got_q) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata_in[7:0];
      wstrb_d = s_axi_wstrb_in[0];
    end
    if (wr_fire) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
    end
  end

  // both halves held, no response pending
  assign wr_fire = aw_got_q && w_got_q && (st_q == pxafe_pkg::PXAFE_IDLE);
  assign awa = waddr_q;
  assign wda = wdata_q;

  // ============================================================
  // register writes; only byte lane 0 carries data
  always_comb begin
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    dac_d   = dac_q;
    trim0_d = trim0_q;
    trim1_d = trim1_q;
    ctrim_d = ctrim_q;
    bresp_d = bresp_q;
    if (wr_fire) begin
      bresp_d = pxafe_pkg::PXAFE_OKAY;
      case (awa)
        `PXAFE_OFF_CTRL0: if (wstrb_q) ctrl0_d = wda;
        `PXAFE_OFF_CTRL1: if (wstrb_q) ctrl1_d = wda[5:0];
        `PXAFE_OFF_DAC:   if (wstrb_q) dac_d = wda;
        `PXAFE_OFF_TRIM0: if (wstrb_q) trim0_d = wda;
        `PXAFE_OFF_TRIM1: if (wstrb_q) trim1_d = wda;
        `PXAFE_OFF_CTRIM: if (wstrb_q) ctrim_d = wda[6:0];
        default: bresp_d = pxafe_pkg::PXAFE_SLVERR;
      endcase
    end
  end

  // ============================================================
  // response state machine: one write or one read at a time
  always_comb begin
    st_d    = st_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    case (st_q)
      pxafe_pkg::PXAFE_IDLE: begin
        if (wr_fire) begin
          st_d = pxafe_pkg::PXAFE_BRSP;
        end else if (s_axi_arvalid_in) begin
          st_d    = pxafe_pkg::PXAFE_RRSP;
          rresp_d = pxafe_pkg::PXAFE_OKAY;
          rdata_d = 32'h0000_0000;
          case (s_axi_araddr_in)
            `PXAFE_OFF_CTRL0: rdata_d[7:0] = ctrl0_q;
            `PXAFE_OFF_CTRL1:
              rdata_d[7:0] = {amp_one_cal_output_in,
                              amp_zero_cal_output_in, ctrl1_q};
            `PXAFE_OFF_DAC:   rdata_d[7:0] = dac_q;
            `PXAFE_OFF_TRIM0: rdata_d[7:0] = trim0_q;
            `PXAFE_OFF_TRIM1: rdata_d[7:0] = trim1_q;
            `PXAFE_OFF_CTRIM: rdata_d[7:0] = {cmp_q, ctrim_q};
            default: rresp_d = pxafe_pkg::PXAFE_SLVERR;
          endcase
        end
      end
      pxafe_pkg::PXAFE_BRSP: if (s_axi_bready_in) st_d = pxafe_pkg::PXAFE_IDLE;
      pxafe_pkg::PXAFE_RRSP: if (s_axi_rready_in) st_d = pxafe_pkg::PXAFE_IDLE;
      default: st_d = pxafe_pkg::PXAFE_IDLE;
    endcase
  end

  // ============================================================
  // debounce: limit is 2^n - 1 stable cycles after the change cycle
  always_comb begin
    deb_limit = 7'h00;
    case (ctrl0_q[2:0])
      3'h1: deb_limit = 7'h01;
      3'h2: deb_limit = 7'h03;
      3'h3: deb_limit = 7'h07;
      3'h4: deb_limit = 7'h0F;
      3'h5: deb_limit = 7'h1F;
      3'h6: deb_limit = 7'h3F;
      3'h7: deb_limit = 7'h7F;
      default: deb_limit = 7'h00;
    endcase
  end

  always_comb begin
    // disabled comparator reads low
    cmp_d      = ctrl0_q[`PXAFE_C0_CMP_ON] & comparator_raw_in;
    raw_last_d = cmp_q;
    deb_cnt_d  = deb_cnt_q;
    filt_d     = filt_q;
    if (ctrl0_q[2:0] == 3'h0) begin
      filt_d    = cmp_q;
      deb_cnt_d = 7'h00;
    end else if (cmp_q != raw_last_q) begin
      deb_cnt_d = `PXAFE_TICK_CYCLES;
    end else if (cmp_q != filt_q) begin
      if (deb_cnt_q >= deb_limit) begin
        filt_d    = cmp_q;
        deb_cnt_d = 7'h00;
      end else begin
        deb_cnt_d = deb_cnt_q + 7'h01;
      end
    end else begin
      deb_cnt_d = 7'h00;
    end
    // one-cycle request on the selected edge of the filtered result
    case (ctrl0_q[4:3])
      pxafe_pkg::PXAFE_EDGE_RISE: irq_d = filt_d & ~filt_q;
      pxafe_pkg::PXAFE_EDGE_FALL: irq_d = ~filt_d & filt_q;
      pxafe_pkg::PXAFE_EDGE_BOTH: irq_d = filt_d ^ filt_q;
      default: irq_d = 1'b0;
    endcase
  end

  // ============================================================
  // registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl0_q    <= `PXAFE_RST_CTRL0;
      ctrl1_q    <= `PXAFE_RST_CTRL1;
      dac_q      <= `PXAFE_RST_DAC;
      trim0_q    <= `PXAFE_RST_TRIM;
      trim1_q    <= `PXAFE_RST_TRIM;
      ctrim_q    <= `PXAFE_RST_CTRIM;
      aw_got_q   <= 1'b0;
      w_got_q    <= 1'b0;
      waddr_q    <= 8'h00;
      wdata_q    <= 8'h00;
      wstrb_q    <= 1'b0;
      bresp_q    <= 2'h0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= 2'h0;
      st_q       <= pxafe_pkg::PXAFE_IDLE;
      cmp_q      <= 1'b0;
      raw_last_q <= 1'b0;
      deb_cnt_q  <= 7'h00;
      filt_q     <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      ctrl0_q    <= ctrl0_d;
      ctrl1_q    <= ctrl1_d;
      dac_q      <= dac_d;
      trim0_q    <= trim0_d;
      trim1_q    <= trim1_d;
      ctrim_q    <= ctrim_d;
      aw_got_q   <= aw_got_d;
      w_got_q    <= w_got_d;
      waddr_q    <= waddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      bresp_q    <= bresp_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      st_q       <= st_d;
      cmp_q      <= cmp_d;
      raw_last_q <= raw_last_d;
      deb_cnt_q  <= deb_cnt_d;
      filt_q     <= filt_d;
      irq_q      <= irq_d;
    end
  end

  // ============================================================
  // outputs, all from flip-flops; the bus ready and valid outputs through small decodes of them
  assign s_axi_awready_out = !aw_got_q;
  assign s_axi_wready_out  = !w_got_q;
  assign s_axi_bvalid_out  = (st_q == pxafe_pkg::PXAFE_BRSP);
  assign s_axi_bresp_out   = bresp_q;
  assign s_axi_arready_out = (st_q == pxafe_pkg::PXAFE_IDLE) && !wr_fire;
  assign s_axi_rvalid_out  = (st_q == pxafe_pkg::PXAFE_RRSP);
  assign s_axi_rdata_out   = rdata_q;
  assign s_axi_rresp_out   = rresp_q;
  assign amp_one_on_out    = ctrl0_q[`PXAFE_C0_AMP1_ON];
  assign amp_zero_on_out   = ctrl0_q[`PXAFE_C0_AMP0_ON];
  assign comparator_dac_on_out = ctrl0_q[`PXAFE_C0_CMP_ON];
  assign hysteresis_select_out      = ctrl1_q[5:4];
  assign comparator_bias_select_out = ctrl1_q[3:2];
  assign amp_one_speed_select_out   = ctrl1_q[1];
  assign amp_zero_speed_select_out  = ctrl1_q[0];
  assign reference_dac_code_out     = dac_q;
  assign amp_zero_trim_out          = trim0_q;
  assign amp_one_trim_out           = trim1_q;
  assign comparator_trim_out        = ctrim_q;
  assign filtered_comparator_result_out = filt_q;
  assign proximity_irq_out          = irq_q;

  // ============================================================
  // checks: one clock; reset masks all but the reset-value check
  default clocking cb_chk @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_deb2_change;
    ctrl0_q[2:0] == 3'h2 && $changed(cmp_q);
  endsequence
  sequence s_deb2_steady;
    (ctrl0_q[2:0] == 3'h2 && $stable(cmp_q) && cmp_q != filt_q) [*3];
  endsequence
  a_irq_rise: assert property (
    ($past(ctrl0_q[4:3]) == 2'h1 && $rose(filt_q)) |-> proximity_irq_out)
    else $error("rising edge missed");
  a_irq_none: assert property (
    ($past(ctrl0_q[4:3]) == 2'h0) |-> !proximity_irq_out)
    else $error("irq while disabled");
  a_cmp_off: assert property (
    !$past(ctrl0_q[`PXAFE_C0_CMP_ON]) |-> !cmp_q)
    else $error("comparator not forced low");
  a_bypass_pass: assert property (
    (ctrl0_q[2:0] == 3'h0) |=> (filt_q == $past(cmp_q)))
    else $error("bypass not transparent");
  a_deb_hold: assert property (
    s_deb2_change |=> $stable(filt_q))
    else $error("filter moved early");
  a_deb_fire: assert property (
    s_deb2_change ##1 s_deb2_steady |=> filt_q == $past(cmp_q))
    else $error("filter missed its count");
  a_deb_max: assert property (
    deb_cnt_q <= $past(deb_limit))
    else $error("debounce count out of range");
  a_amp_en: assert property (
    (wr_fire && awa == `PXAFE_OFF_CTRL0 && wstrb_q) |=>
    amp_one_on_out == $past(wda[7]) && amp_zero_on_out == $past(wda[6]))
    else $error("amp enable mismatch");
  a_trim_rst: assert property (disable iff (1'b0)
    sys_rst_in |=> amp_zero_trim_out == `PXAFE_RST_TRIM &&
    comparator_trim_out == `PXAFE_RST_CTRIM)
    else $error("trim reset value wrong");
endmodule

// ### pxafe_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: included by the control module only
// Notes:   register offsets are byte addresses on a 32-bit bus
`ifndef PXAFE_MAP_SVH
`define PXAFE_MAP_SVH
// ============================================================
// register byte offsets
`define PXAFE_OFF_CTRL0   8'h00
`define PXAFE_OFF_CTRL1   8'h04
`define PXAFE_OFF_DAC     8'h08
`define PXAFE_OFF_TRIM0   8'h0C
`define PXAFE_OFF_TRIM1   8'h10
`define PXAFE_OFF_CTRIM   8'h14
// ============================================================
// field positions
`define PXAFE_C0_AMP1_ON  7
`define PXAFE_C0_AMP0_ON  6
`define PXAFE_C0_CMP_ON   5
`define PXAFE_C1_AMP1_CAL 7
`define PXAFE_C1_AMP0_CAL 6
`define PXAFE_CT_RESULT   7
// ============================================================
// reset values
`define PXAFE_RST_CTRL0   8'h00
`define PXAFE_RST_CTRL1   6'h00
`define PXAFE_RST_DAC     8'h00
`define PXAFE_RST_TRIM    8'h20
`define PXAFE_RST_CTRIM   7'h10
// ============================================================
// timing: one debounce tick is one system clock period
`define PXAFE_TICK_CYCLES 7'h01
`endif

// ### pxafe_pkg.sv
// Purpose: types shared by the proximity front end control
// Assumes: nothing beyond the map header
// Notes:   holds types only
package pxafe_pkg;
  // ============================================================
  // response codes of the register bus
  typedef enum logic [1:0] {
    PXAFE_OKAY   = 2'h0,
    PXAFE_SLVERR = 2'h2
  } pxafe_resp_t;
  // ============================================================
  // interrupt edge selection
  typedef enum logic [1:0] {
    PXAFE_EDGE_NONE = 2'h0,
    PXAFE_EDGE_RISE = 2'h1,
    PXAFE_EDGE_FALL = 2'h2,
    PXAFE_EDGE_BOTH = 2'h3
  } pxafe_edge_t;
  // ============================================================
  // bus slave states, one-hot
  typedef enum logic [2:0] {
    PXAFE_IDLE = 3'h1,
    PXAFE_BRSP = 3'h2,
    PXAFE_RRSP = 3'h4
  } pxafe_state_t;
endpackage

// ### pxafe_analog_model.sv
// Purpose: behavioural analog side: amps, comparator, reference DAC
// Assumes: analog results settle within the cycle that sets the codes
// Notes:   trip points are plain constants, not silicon figures
`timescale 1ns/1ps
module pxafe_analog_model #(
  parameter logic [5:0] AMP_TRIP = 6'h17,
  parameter logic [4:0] CMP_TRIP = 5'h0B
) (
  input  wire logic       amp_zero_on_in,
  input  wire logic       amp_one_on_in,
  input  wire logic [7:0] reference_dac_code_in,
  input  wire logic [7:0] amp_zero_trim_in,
  input  wire logic [7:0] amp_one_trim_in,
  input  wire logic [6:0] comparator_trim_in,
  input  wire logic [7:0] sense_level_in,
  output logic            comparator_raw_out,
  output logic            amp_zero_cal_output_out,
  output logic            amp_one_cal_output_out
);
  // ============================================================
  // amp outputs: flip once the trim passes the trip point in cal mode
  assign amp_zero_cal_output_out = amp_zero_on_in && amp_zero_trim_in[7]
    && (amp_zero_trim_in[5:0] >= AMP_TRIP);
  assign amp_one_cal_output_out = amp_one_on_in && amp_one_trim_in[7]
    && (amp_one_trim_in[5:0] >= AMP_TRIP);
  // ============================================================
  // comparator: not gated here, so the block's own forcing must show
  assign comparator_raw_out = comparator_trim_in[6]
    ? (comparator_trim_in[4:0] >= CMP_TRIP)
    : (sense_level_in > reference_dac_code_in);
endmodule

// ### proximity_afe_control_tb.sv
// Purpose: register, calibration and debounce tests of the AFE control
// Assumes: AXI4-Lite slave answers within a few cycles; bus waits are unbounded, settle stops at 300 cycles, the watchdog at cycle 40000
// Notes:   trip points of the model fix the expected calibration results
`timescale 1ns/1ps
module proximity_afe_control_tb;
  logic clk_in = 1'b0, sys_rst_in = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, sense = 8'h00;
  logic [31:0] wdata = 32'h0, rdat, rv;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, raw, c0, c1, flt, irq;
  logic a0_on, a1_on, c_on, sp0, sp1;
  logic [1:0] bresp, rresp, hys, bias, resp;
  logic [7:0] dac, t0, t1;
  logic [6:0] ct;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, irq_cnt = 0, v1, v2, d, k;
  initial forever #4 clk_in = ~clk_in;
  pxafe_ctrl u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .comparator_raw_in(raw),
    .amp_zero_cal_output_in(c0), .amp_one_cal_output_in(c1),
    .amp_zero_on_out(a0_on), .amp_one_on_out(a1_on),
    .comparator_dac_on_out(c_on), .amp_zero_speed_select_out(sp0),
    .amp_one_speed_select_out(sp1), .hysteresis_select_out(hys),
    .comparator_bias_select_out(bias), .reference_dac_code_out(dac),
    .amp_zero_trim_out(t0), .amp_one_trim_out(t1),
    .comparator_trim_out(ct), .filtered_comparator_result_out(flt),
    .proximity_irq_out(irq));
  pxafe_analog_model u_ana (.amp_zero_on_in(a0_on), .amp_one_on_in(a1_on),
    .reference_dac_code_in(dac), .amp_zero_trim_in(t0),
    .amp_one_trim_in(t1), .comparator_trim_in(ct), .sense_level_in(sense),
    .comparator_raw_out(raw), .amp_zero_cal_output_out(c0),
    .amp_one_cal_output_out(c1));
  // ============================================================
  // watchdog and pulse counter
  always @(posedge clk_in) begin
    cyc++;
    if (irq === 1'b1) irq_cnt++;
    if (cyc == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ============================================================
  // bus tasks: payload held until its own ready is sampled high
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (bvalid === 1'b1 && aw_ok && w_ok) break;
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 0;
      end
    end
    resp = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (!arvalid && rvalid === 1'b1) break;
      if (arvalid && arready === 1'b1) arvalid <= 0;
    end
    v = rdat;
    resp = rresp;
    rready <= 0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [7:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(nm, {24'h0, e}, v);
    chk("rresp", 32'h0, {30'h0, resp});
  endtask
  // sweep a trim field up then down, record both flips, load the mean
  task automatic sweep(input logic [7:0] a, pre, mx, input int bp);
    logic [31:0] v;
    logic b0;
    wr(a, {24'h0, pre});
    rd(bp == 6 ? 8'h04 : a, v);
    b0 = v[bp];
    for (k = 1; k <= mx; k++) begin
      wr(a, {24'h0, pre | 8'(k)});
      rd(bp == 6 ? 8'h04 : a, v);
      if (v[bp] !== b0) break;
    end
    v1 = k;
    wr(a, {24'h0, pre | mx});
    rd(bp == 6 ? 8'h04 : a, v);
    b0 = v[bp];
    for (k = mx - 1; k >= 0; k--) begin
      wr(a, {24'h0, pre | 8'(k)});
      rd(bp == 6 ? 8'h04 : a, v);
      if (v[bp] !== b0) break;
    end
    v2 = k;
    wr(a, {24'h0, pre | 8'((v1 + v2) / 2)});
  endtask
  // set the sense level, count cycles to the filtered change
  task automatic settle(input logic [7:0] lv);
    @(posedge clk_in);
    sense <= lv;
    for (d = 0; d < 300 && flt !== (lv > 8'h80); d++) @(posedge clk_in);
  endtask
  // ============================================================
  initial begin
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 0;
    rchk("ctrl0", 8'h00, 8'h00);
    rchk("ctrl1", 8'h04, 8'h00);
    rchk("dac", 8'h08, 8'h00);
    rchk("trim0", 8'h0C, 8'h20);
    rchk("trim1", 8'h10, 8'h20);
    rchk("ctrim", 8'h14, 8'h10);
    rd(8'h18, rv);
    chk("unmapped rresp", 32'h2, {30'h0, resp});
    $display("reset test done");
    wr(8'h00, 32'hE0);
    chk("enables", 32'h7, {29'h0, a1_on, a0_on, c_on});
    wr(8'h04, 32'hFF);
    chk("ctrl1 outs", 32'hF, {28'h0, hys, bias});
    chk("speed", 32'h3, {30'h0, sp1, sp0});
    rchk("ctrl1 rd", 8'h04, 8'h3F);
    wr(8'h08, 32'hA5);
    chk("dac out", 32'hA5, {24'h0, dac});
    wr(8'h1C, 32'hFF);
    chk("unmapped bresp", 32'h2, {30'h0, resp});
    rchk("dac kept", 8'h08, 8'hA5);
    // lane 0 strobe low: no write, still an OKAY answer
    wstrb <= 4'hE;
    wr(8'h08, 32'h5A);
    chk("strobe resp", 32'h0, {30'h0, resp});
    chk("strobe off", 32'hA5, {24'h0, dac});
    wstrb <= 4'hF;
    $display("register test done");
    wr(8'h0C, 32'h80);
    sweep(8'h0C, 8'hC0, 8'h3F, 6);
    chk("amp trim", 32'hD6, {24'h0, t0});
    wr(8'h10, 32'hFF);
    chk("amp one trim", 32'hFF, {24'h0, t1});
    rchk("amp one out", 8'h04, 8'hBF);
    wr(8'h14, 32'h40);
    sweep(8'h14, 8'h60, 8'h1F, 7);
    chk("cmp trim", 32'h6A, {25'h0, ct});
    wr(8'h14, 32'h0A);
    $display("calibration test done");
    wr(8'h08, 32'h80);
    for (int n = 0; n < 8; n++) begin
      wr(8'h00, 32'h38 | n);
      k = irq_cnt;
      settle(8'hFF);
      v1 = (n == 0) ? 1 : (1 << n) - 1;
      v2 = (n == 0) ? 3 : (1 << n) + 3;
      chk("deb rise", 32'h1, {31'h0, d >= v1 && d <= v2});
      settle(8'h00);
      chk("deb fall", 32'h1, {31'h0, d >= v1 && d <= v2});
      // let the pulse counter see the last pulse before it is compared
      repeat (2) @(posedge clk_in);
      chk("irq both", 32'h2, 32'(irq_cnt - k));
    end
    for (int e = 0; e < 4; e++) begin
      wr(8'h00, 32'h20 | (e << 3));
      k = irq_cnt;
      settle(8'hFF);
      repeat (4) @(posedge clk_in);
      chk("irq rise", 32'(e & 1), 32'(irq_cnt - k));
      settle(8'h00);
      repeat (4) @(posedge clk_in);
      chk("irq all", 32'((e & 1) + (e >> 1)), 32'(irq_cnt - k));
    end
    wr(8'h00, 32'h3B);
    k = irq_cnt;
    @(posedge clk_in);
    sense <= 8'hFF;
    repeat (3) @(posedge clk_in);
    sense <= 8'h00;
    repeat (20) @(posedge clk_in);
    chk("glitch", 32'h0, 32'(irq_cnt - k));
    wr(8'h00, 32'h18);
    settle(8'hFF);
    chk("cmp off", 32'h0, {31'h0, flt});
    rchk("cmp off rd", 8'h14, 8'h0A);
    chk("cmp off irq", 32'h0, 32'(irq_cnt - k));
    $display("comparator test done");
    give_verdict();
  end
endmodule
